// [rtl/mphi_defines.vh]
`ifndef MPHI_DEFINES_VH
`define MPHI_DEFINES_VH
// =========================================================
// Interface select strap codes, written {bit2,bit1,bit0}.
`define MPHI_SEL_I2C 3'h2
`define MPHI_SEL_SERIAL 3'h0
`define MPHI_SEL_E4 3'h5
`define MPHI_SEL_S4 3'h7
`define MPHI_SEL_E8 3'h4
`define MPHI_SEL_S8 3'h6
// =========================================================
// Character table strap codes, written {sel1,sel0}.
`define MPHI_ROM_FIRST 2'h0
`define MPHI_ROM_SECOND 2'h1
`define MPHI_ROM_THIRD 2'h2
`define MPHI_ROM_SOFT 2'h3
// =========================================================
// I2C slave address upper bits and byte width.
`define MPHI_I2C_ADDR_HI 6'h1e
`define MPHI_BYTE_W 8
`define MPHI_FIFO_DEPTH 2
`endif

// [rtl/mphi_fifo.v]
`timescale 1ns/100ps
// =========================================================
// Two-entry buffer with valid and ready on both sides.
module mphi_fifo #(
  parameter WIDTH = 9
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_ff [0:1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule // mphi_fifo

// [rtl/mphi_host_if.v]
`timescale 1ns/100ps
// Overview of operation
// - Straps select I2C, serial, or 4/8-bit enable or split strobe buses.
// - While hw_init_n is low, all controller and interface state resets.
// - Transfers are accepted only while chip select is low.
// - Parallel: data/command high means display data, low means command.
// - Serial: data/command select steers shifted bytes the same way.
// - I2C: data/command pin is the slave address low bit.
// - Enable-strobe: a cycle starts when the strobe rises with select low.
// - Split-strobe: read starts on read strobe low with select low.
// - Enable-strobe: direction high requests read, low requests write.
// - Split-strobe: direction pin is a low write strobe starting a write.
// - Serial: bus bit 1 is serial input, bit 0 serial clock.
// - All eight host bus lines are driven by the device only in parallel reads; an I2C acknowledge drives bit 2 alone.
// - Two straps pick the character table, or leave it to software.
`include "mphi_defines.vh"
module mphi_host_if #(
  parameter BYTE_W = `MPHI_BYTE_W
) (
  // Clock and reset
  input wire REF_CLK,
  input wire SRST,
  // Straps
  input wire IFACE_SEL_BIT0,
  input wire IFACE_SEL_BIT1,
  input wire IFACE_SEL_BIT2,
  input wire CHAR_TABLE_SEL0,
  input wire CHAR_TABLE_SEL1,
  // Host pins
  input wire HW_INIT_N,
  input wire CS_N,
  input wire DC_SEL,
  input wire E_RD_N,
  input wire RW_WR_N,
  input wire [7:0] HOST_BUS_IN,
  output reg [7:0] HOST_BUS_OUT,
  output reg [7:0] HOST_BUS_OE,
  // Received byte stream toward the controller core
  output reg RX_VALID,
  input wire RX_READY,
  output reg [BYTE_W-1:0] RX_BYTE,
  output reg RX_IS_DATA,
  // Read data supplied by the core
  input wire [BYTE_W-1:0] RD_BYTE,
  // Status
  output reg [2:0] MODE,
  output reg [1:0] CHAR_TABLE,
  output reg I2C_ADDR_LSB,
  output reg INIT_ACTIVE,
  output reg OVERRUN
);
  // =========================================================
  // Mode decode.
  // The init pin is a second synchronous reset, so both clear the same state.
  wire rst = SRST || !HW_INIT_N;
  wire [2:0] sel = {IFACE_SEL_BIT2, IFACE_SEL_BIT1, IFACE_SEL_BIT0};
  reg [2:0] mode_ff;
  wire m_ser = (mode_ff == `MPHI_SEL_SERIAL);
  wire m_i2c = (mode_ff == `MPHI_SEL_I2C);
  wire m_e = (mode_ff == `MPHI_SEL_E4) || (mode_ff == `MPHI_SEL_E8);
  wire m_s = (mode_ff == `MPHI_SEL_S4) || (mode_ff == `MPHI_SEL_S8);
  wire m_4 = (mode_ff == `MPHI_SEL_E4) || (mode_ff == `MPHI_SEL_S4);
  // Codes 001 and 011 select no link; refusing them means a strap that
  // passes through one of them on its way to a new setting changes nothing.
  wire sel_ok = (sel != 3'h1) && (sel != 3'h3);
  wire cs = !CS_N;

  // =========================================================
  // Edge history of the host strobes.
  // Each history flop resets to the level that its detector treats as
  // inactive, so the first cycle after reset never reports a false edge.
  reg e_ff;
  reg rd_n_ff;
  reg wr_n_ff;
  reg sclk_ff;
  reg sda_ff;
  always @(posedge REF_CLK) begin
    if (rst) begin
      e_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      e_ff <= E_RD_N;
      rd_n_ff <= E_RD_N;
      wr_n_ff <= RW_WR_N;
      sclk_ff <= HOST_BUS_IN[0];
      sda_ff <= HOST_BUS_IN[1];
    end
  end

  // Strobes are qualified by chip select so idle bus noise is ignored, except e_fall and i2c_stop, which only end transfers.
  wire e_rise = cs && m_e && E_RD_N && !e_ff;
  wire e_fall = m_e && !E_RD_N && e_ff;
  wire par_wr = (e_rise && !RW_WR_N) ||
    (cs && m_s && !RW_WR_N && wr_n_ff);
  wire par_rd_start = (e_rise && RW_WR_N) ||
    (cs && m_s && !E_RD_N && rd_n_ff);
  wire sclk_rise = cs && m_ser && HOST_BUS_IN[0] && !sclk_ff;
  wire scl_rise = cs && m_i2c && HOST_BUS_IN[0] && !sclk_ff;
  wire scl_fall = cs && m_i2c && !HOST_BUS_IN[0] && sclk_ff;
  // Start and stop are seen one sample late, so the host must keep SDA
  // steady for at least one clock cycle around each SCL edge.
  wire i2c_start = cs && m_i2c && HOST_BUS_IN[0] && sclk_ff &&
    sda_ff && !HOST_BUS_IN[1];
  wire i2c_stop = m_i2c && HOST_BUS_IN[0] && sclk_ff &&
    !sda_ff && HOST_BUS_IN[1];

  // =========================================================
  // Byte assembly for all links.
  // One shift register and bit counter serve both serial links; only one
  // link is live at a time, so sharing them costs nothing.
  reg [7:0] shift_ff;
  reg [3:0] bits_ff;
  reg nib_hi_ff;
  reg [3:0] nib_ff;
  reg push_ff;
  reg [8:0] push_word_ff;
  reg [1:0] i2c_st_ff;
  reg i2c_dc_ff;
  reg i2c_ack_ff;
  reg i2c_drive_ff;
  // I2C transfer phases: waiting, address, control byte, data bytes.
  localparam I2C_IDLE = 2'h0;
  localparam I2C_ADDR = 2'h1;
  localparam I2C_CTRL = 2'h2;
  localparam I2C_BYTE = 2'h3;
  // The low address bit follows the data/command pin at all times.
  wire [6:0] my_addr = {`MPHI_I2C_ADDR_HI, DC_SEL};
  wire fifo_ready;

  always @(posedge REF_CLK) begin
    if (rst) begin
      mode_ff <= `MPHI_SEL_SERIAL;
      shift_ff <= 8'h00;
      bits_ff <= 4'h0;
      nib_hi_ff <= 1'b1;
      nib_ff <= 4'h0;
      push_ff <= 1'b0;
      push_word_ff <= 9'h000;
      i2c_st_ff <= I2C_IDLE;
      i2c_dc_ff <= 1'b0;
      i2c_ack_ff <= 1'b0;
      i2c_drive_ff <= 1'b0;
      OVERRUN <= 1'b0;
    end else begin
      // Straps are captured while idle; a bad code keeps the last mode.
      if (!cs && sel_ok) begin
        mode_ff <= sel;
      end
      push_ff <= 1'b0;
      // A byte offered to a full buffer is dropped; the loss stays marked
      // until the next reset, because the core cannot recover the byte.
      if (push_ff && !fifo_ready) begin
        OVERRUN <= 1'b1;
      end
      // In 4-bit modes a high nibble waits in nib_ff; a host that stops
      // after one nibble leaves it pending until its next write.
      if (par_wr) begin
        if (!m_4) begin
          push_ff <= 1'b1;
          push_word_ff <= {DC_SEL, HOST_BUS_IN};
        end else if (nib_hi_ff) begin
          nib_ff <= HOST_BUS_IN[7:4];
          nib_hi_ff <= 1'b0;
        end else begin
          push_ff <= 1'b1;
          push_word_ff <= {DC_SEL, nib_ff, HOST_BUS_IN[7:4]};
          nib_hi_ff <= 1'b1;
        end
      end
      if (!cs) begin
        bits_ff <= 4'h0;
      end else if (sclk_rise) begin
        shift_ff <= {shift_ff[6:0], HOST_BUS_IN[1]};
        if (bits_ff == 4'h7) begin
          bits_ff <= 4'h0;
          push_ff <= 1'b1;
          push_word_ff <= {DC_SEL, shift_ff[6:0], HOST_BUS_IN[1]};
        end else begin
          bits_ff <= bits_ff + 4'h1;
        end
      end
      // I2C: address with own low bit, control byte (bit 6 = data), bytes.
      if (i2c_start) begin
        i2c_st_ff <= I2C_ADDR;
        bits_ff <= 4'h0;
        i2c_ack_ff <= 1'b0;
      end else if (i2c_stop || !cs) begin
        i2c_st_ff <= I2C_IDLE;
        i2c_drive_ff <= 1'b0;
      end else if (scl_rise && !i2c_ack_ff && i2c_st_ff != I2C_IDLE) begin
        shift_ff <= {shift_ff[6:0], HOST_BUS_IN[1]};
        bits_ff <= bits_ff + 4'h1;
      end else if (scl_fall) begin
        i2c_drive_ff <= 1'b0;
        if (i2c_ack_ff) begin
          i2c_ack_ff <= 1'b0;
          bits_ff <= 4'h0;
        end else if (bits_ff == 4'h8) begin
          i2c_ack_ff <= 1'b1;
          // Only a write to our own address is answered; reads are not
          // offered on this link.
          case (i2c_st_ff)
            I2C_ADDR: begin
              if (shift_ff[7:1] == my_addr && !shift_ff[0]) begin
                i2c_drive_ff <= 1'b1;
                i2c_st_ff <= I2C_CTRL;
              end else begin
                i2c_st_ff <= I2C_IDLE;
              end
            end
            I2C_CTRL: begin
              i2c_drive_ff <= 1'b1;
              i2c_dc_ff <= shift_ff[6];
              i2c_st_ff <= I2C_BYTE;
            end
            I2C_BYTE: begin
              i2c_drive_ff <= 1'b1;
              push_ff <= 1'b1;
              push_word_ff <= {i2c_dc_ff, shift_ff};
            end
            default: begin
              i2c_st_ff <= I2C_IDLE;
            end
          endcase
        end
      end
    end
  end

  // =========================================================
  // Buffer toward the core; a core stalled past three bytes loses the later ones.
  // Two entries behind the output register cover a core that stalls for
  // the length of a couple of host writes.
  wire fifo_valid;
  wire [8:0] fifo_data;
  // The output register reloads whenever it is empty or being drained.
  wire take = fifo_valid && (!RX_VALID || RX_READY);
  mphi_fifo #(
    .WIDTH(9)
  ) u_fifo (
    .clk(REF_CLK),
    .srst(rst),
    .in_valid(push_ff),
    .in_ready(fifo_ready),
    .in_data(push_word_ff),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(fifo_data)
  );

  // =========================================================
  // Outputs and read drive.
  reg rd_active_ff;
  always @(posedge REF_CLK) begin
    if (rst) begin
      RX_VALID <= 1'b0;
      RX_BYTE <= {BYTE_W{1'b0}};
      RX_IS_DATA <= 1'b0;
      HOST_BUS_OUT <= 8'h00;
      HOST_BUS_OE <= 8'h00;
      rd_active_ff <= 1'b0;
      MODE <= `MPHI_SEL_SERIAL;
      CHAR_TABLE <= `MPHI_ROM_FIRST;
      I2C_ADDR_LSB <= 1'b0;
      INIT_ACTIVE <= 1'b1;
    end else begin
      // INIT_ACTIVE stays high for one cycle after the reset is released.
      INIT_ACTIVE <= 1'b0;
      MODE <= mode_ff;
      CHAR_TABLE <= {CHAR_TABLE_SEL1, CHAR_TABLE_SEL0};
      I2C_ADDR_LSB <= DC_SEL;
      if (take) begin
        RX_VALID <= 1'b1;
        RX_BYTE <= fifo_data[7:0];
        RX_IS_DATA <= fifo_data[8];
      end else if (RX_READY) begin
        RX_VALID <= 1'b0;
      end
      // A read ends when its strobe goes inactive or the chip is deselected.
      if (par_rd_start) begin
        rd_active_ff <= 1'b1;
      end else if (!cs || e_fall || (m_s && E_RD_N)) begin
        rd_active_ff <= 1'b0;
      end
      // The drive lags the strobe by two cycles, so a host must hold its
      // read strobe for at least two cycles before it samples the bus.
      HOST_BUS_OUT <= RD_BYTE;
      if (m_i2c) begin
        // The acknowledge pulls bus bit 2 low; bit 1 is only watched.
        HOST_BUS_OUT <= 8'h00;
        HOST_BUS_OE <= {5'h00, i2c_drive_ff, 2'h0};
      end else if (rd_active_ff && cs && (m_e || m_s)) begin
        HOST_BUS_OE <= 8'hff;
      end else begin
        HOST_BUS_OE <= 8'h00;
      end
    end
  end
endmodule // mphi_host_if

// [bench/mphi_host_chk.sv]
`timescale 1ns/100ps
`include "mphi_defines.vh"
// =========================================================
// Temporal checks on the host interface ports.
module mphi_host_chk #(
  parameter BYTE_W = 8
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic HW_INIT_N,
  // Straps and host strobes
  input wire logic CHAR_TABLE_SEL0,
  input wire logic CHAR_TABLE_SEL1,
  input wire logic CS_N,
  input wire logic E_RD_N,
  input wire logic RW_WR_N,
  // Device outputs and stream handshake
  input wire logic [7:0] HOST_BUS_OE,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [BYTE_W-1:0] RX_BYTE,
  input wire logic RX_IS_DATA,
  input wire logic [2:0] MODE,
  input wire logic [1:0] CHAR_TABLE,
  input wire logic INIT_ACTIVE,
  input wire logic OVERRUN
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // =========================================================
  // Assertions.
  AST_RESET: assert property (disable iff (1'b0)
    SRST |=> INIT_ACTIVE && MODE == 3'h0 && !RX_VALID && !OVERRUN)
    else $error("reset state wrong");
  AST_HWINIT: assert property (!HW_INIT_N |=> INIT_ACTIVE && !RX_VALID)
    else $error("init pin ignored");
  AST_MODE_HOLD: assert property (!CS_N && HW_INIT_N |=> $stable(MODE))
    else $error("mode changed while selected");
  AST_CS_RELEASE: assert property (CS_N [*4] |-> HOST_BUS_OE == 8'h00)
    else $error("bus driven while deselected");
  AST_SERIAL_QUIET: assert property (MODE == `MPHI_SEL_SERIAL
    |-> HOST_BUS_OE == 8'h00) else $error("bus driven in serial mode");
  AST_E_READ: assert property (MODE == `MPHI_SEL_E8 && !CS_N && RW_WR_N
    && $rose(E_RD_N) |-> ##[1:3] HOST_BUS_OE == 8'hff)
    else $error("enable read not driven");
  AST_S_READ: assert property (MODE == `MPHI_SEL_S8 && !CS_N
    && $fell(E_RD_N) |-> ##[1:3] HOST_BUS_OE == 8'hff)
    else $error("split read not driven");
  AST_WRITE_NODRIVE: assert property (
    (MODE == `MPHI_SEL_E8 && !CS_N && !RW_WR_N) [*4] |-> HOST_BUS_OE == 8'h00)
    else $error("bus driven during write");
  AST_STALL_HOLD: assert property (RX_VALID && !RX_READY && HW_INIT_N
    |=> RX_VALID && $stable(RX_BYTE) && $stable(RX_IS_DATA))
    else $error("stalled byte changed");
  AST_OVERRUN_STICKY: assert property (OVERRUN && HW_INIT_N |=> OVERRUN)
    else $error("overrun flag lost");
  AST_CHAR_TABLE: assert property (HW_INIT_N |=>
    CHAR_TABLE == {$past(CHAR_TABLE_SEL1), $past(CHAR_TABLE_SEL0)})
    else $error("character table wrong");
  // The covers show that data bytes, reads and overruns were all seen.
  cover property (RX_VALID && RX_READY && RX_IS_DATA);
  cover property (HOST_BUS_OE == 8'hff);
  cover property ($rose(OVERRUN));
endmodule // mphi_host_chk
bind mphi_host_if mphi_host_chk #(.BYTE_W(BYTE_W)) chk (.*);

// [bench/mphi_host_bfm.sv]
`timescale 1ns/100ps
// =========================================================
// Host processor model on the parallel and serial bus.
module mphi_host_bfm (
  input wire logic clk,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  output logic cs_n,
  output logic dc,
  output logic e_rd_n,
  output logic rw_wr_n,
  output logic [7:0] bus_in
);
  logic [7:0] drv = 8'h00;
  logic drv_en = 1'b0;
  initial begin
    cs_n = 1'b1;
    dc = 1'b0;
    e_rd_n = 1'b0;
    rw_wr_n = 1'b1;
  end
  // A released line shows the inverse of its last value, so a missing
  // drive never passes for a match by the simulator's luck.
  assign bus_in = (dev_oe & dev_out) | (~dev_oe & (drv_en ? drv : ~drv));
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic idle(input logic split);
    e_rd_n = split;
    rw_wr_n = 1'b1;
  endtask
  task automatic par(input logic split, input logic rd, input logic d_c,
    input logic [7:0] d, output logic [7:0] seen);
    step();
    cs_n = 1'b0;
    dc = d_c;
    drv = d;
    drv_en = !rd;
    rw_wr_n = split | rd;
    step();
    if (split && rd) e_rd_n = 1'b0;
    else if (split) rw_wr_n = 1'b0;
    else e_rd_n = 1'b1;
    repeat (3) step();
    seen = bus_in;
    e_rd_n = split;
    rw_wr_n = 1'b1;
    step();
    cs_n = 1'b1;
    drv_en = 1'b0;
  endtask
  task automatic ser(input logic d_c, input logic [7:0] d);
    step();
    cs_n = 1'b0;
    dc = d_c;
    drv = 8'h00;
    drv_en = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      drv[1] = d[i];
      drv[0] = 1'b0;
      repeat (2) step();
      drv[0] = 1'b1;
      repeat (2) step();
    end
    drv[0] = 1'b0;
    step();
    cs_n = 1'b1;
    drv_en = 1'b0;
  endtask
endmodule // mphi_host_bfm

// [bench/tb.sv]
`timescale 1ns/100ps
`include "mphi_defines.vh"
module tb;
  logic clk, srst, hw_init_n, rx_ready, s0, s1, s2, t0, t1;
  logic [7:0] rd_byte;
  wire cs_n, dc, e_rd_n, rw_wr_n, rx_valid, rx_is_data, i2c_lsb;
  wire init_act, overrun;
  wire [7:0] bus_in, bus_out, bus_oe, rx_byte;
  wire [2:0] mode;
  wire [1:0] ctab;
  logic [8:0] rxq[$];
  int errors = 0;
  int tests_run = 0;
  mphi_host_if #(.BYTE_W(8)) uut (
    .REF_CLK(clk), .SRST(srst), .IFACE_SEL_BIT0(s0), .IFACE_SEL_BIT1(s1),
    .IFACE_SEL_BIT2(s2), .CHAR_TABLE_SEL0(t0), .CHAR_TABLE_SEL1(t1),
    .HW_INIT_N(hw_init_n), .CS_N(cs_n), .DC_SEL(dc), .E_RD_N(e_rd_n),
    .RW_WR_N(rw_wr_n), .HOST_BUS_IN(bus_in), .HOST_BUS_OUT(bus_out),
    .HOST_BUS_OE(bus_oe), .RX_VALID(rx_valid), .RX_READY(rx_ready),
    .RX_BYTE(rx_byte), .RX_IS_DATA(rx_is_data), .RD_BYTE(rd_byte),
    .MODE(mode), .CHAR_TABLE(ctab), .I2C_ADDR_LSB(i2c_lsb),
    .INIT_ACTIVE(init_act), .OVERRUN(overrun));
  mphi_host_bfm bfm (.clk(clk), .dev_out(bus_out), .dev_oe(bus_oe),
    .cs_n(cs_n), .dc(dc), .e_rd_n(e_rd_n), .rw_wr_n(rw_wr_n),
    .bus_in(bus_in));
  // =========================================================
  // Byte monitor and shared helpers.
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      rxq.push_back({rx_is_data, rx_byte});
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] e,
    input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic get(input logic [8:0] e);
    int n;
    n = 0;
    while (rxq.size() == 0 && n < 60) begin
      step();
      n++;
    end
    if (rxq.size() == 0) begin
      errors++;
      $display("[FAIL] rx expected %h seen none", e);
      wrap_up();
    end
    else chk("rx", e, rxq.pop_front());
  endtask
  task automatic none();
    repeat (10) step();
    chk("no_byte", 9'h0, {8'h0, rxq.size() != 0});
  endtask
  // Straps are given in the order bit0, bit1, bit2.
  task automatic set_mode(input logic [2:0] doc);
    repeat (4) step();
    {s0, s1, s2} = doc;
    repeat (3) step();
  endtask
  // =========================================================
  // Scenarios.
  task automatic t_init();
    chk("init_done", 9'h0, {8'h0, init_act});
    chk("mode_rst", {6'h0, `MPHI_SEL_SERIAL}, {6'h0, mode});
    hw_init_n = 1'b0;
    step();
    chk("init_busy", 9'h1, {8'h0, init_act});
    hw_init_n = 1'b1;
    repeat (2) step();
  endtask
  task automatic t_straps();
    logic [2:0] doc [6] = '{3'b010, 3'b000, 3'b101, 3'b111, 3'b001, 3'b011};
    logic [2:0] code [6] = '{`MPHI_SEL_I2C, `MPHI_SEL_SERIAL, `MPHI_SEL_E4,
      `MPHI_SEL_S4, `MPHI_SEL_E8, `MPHI_SEL_S8};
    logic [1:0] tab [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
    logic [1:0] tcode [4] = '{`MPHI_ROM_FIRST, `MPHI_ROM_SECOND,
      `MPHI_ROM_THIRD, `MPHI_ROM_SOFT};
    for (int i = 0; i < 6; i++) begin
      set_mode(doc[i]);
      chk("mode", {6'h0, code[i]}, {6'h0, mode});
    end
    set_mode(3'b110);
    chk("mode_bad", {6'h0, `MPHI_SEL_S8}, {6'h0, mode});
    for (int i = 0; i < 4; i++) begin
      {t0, t1} = tab[i];
      repeat (3) step();
      chk("char_table", {7'h0, tcode[i]}, {7'h0, ctab});
    end
  endtask
  task automatic t_par(input logic split);
    logic [7:0] seen;
    set_mode(split ? 3'b011 : 3'b001);
    bfm.idle(split);
    if (!split) begin
      step();
      // Strobe activity with the chip deselected must leave no trace.
      bfm.rw_wr_n = 1'b0;
      bfm.e_rd_n = 1'b1;
      repeat (2) step();
      bfm.idle(split);
      none();
    end
    bfm.par(split, 1'b0, 1'b1, 8'ha5, seen);
    get(9'h1a5);
    bfm.par(split, 1'b0, 1'b0, 8'h3c, seen);
    get(9'h03c);
    bfm.par(split, 1'b1, 1'b0, 8'h00, seen);
    chk("read_bus", {1'b0, rd_byte}, {1'b0, seen});
    none();
  endtask
  task automatic t_nib();
    logic [7:0] seen;
    set_mode(3'b101);
    bfm.idle(1'b0);
    bfm.par(1'b0, 1'b0, 1'b0, 8'h70, seen);
    bfm.par(1'b0, 1'b0, 1'b1, 8'hb0, seen);
    get(9'h17b);
  endtask
  task automatic t_serial();
    set_mode(3'b000);
    bfm.ser(1'b1, 8'hc3);
    get(9'h1c3);
    bfm.ser(1'b0, 8'h5a);
    get(9'h05a);
  endtask
  task automatic t_i2c();
    set_mode(3'b010);
    for (int i = 0; i < 2; i++) begin
      bfm.dc = i[0];
      repeat (3) step();
      chk("addr_lsb", {8'h0, i[0]}, {8'h0, i2c_lsb});
    end
  endtask
  task automatic t_buf();
    logic [7:0] seen;
    set_mode(3'b001);
    bfm.idle(1'b0);
    rx_ready = 1'b0;
    for (int i = 0; i < 4; i++)
      bfm.par(1'b0, 1'b0, 1'b1, 8'h10 + i[7:0], seen);
    chk("overrun", 9'h1, {8'h0, overrun});
    rx_ready = 1'b1;
    get(9'h110);
    get(9'h111);
    get(9'h112);
    repeat (10) step();
    chk("drained", 9'h0, {8'h0, rx_valid});
    rxq.delete();
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    hw_init_n = 1'b1;
    rx_ready = 1'b1;
    {s0, s1, s2, t0, t1} = 5'h00;
    rd_byte = 8'h96;
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (2) step();
    t_init();
    t_straps();
    t_par(1'b0);
    t_par(1'b1);
    t_nib();
    t_serial();
    t_i2c();
    t_buf();
    wrap_up();
  end
endmodule // tb
